// ### hw/cifc_params.svh
// Constants for the CPU interrupt flag control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CIFC_PARAMS_SVH
`define CIFC_PARAMS_SVH

`define CIFC_ADDR_W 12
`define CIFC_OFF_FLAG 12'h000
`define CIFC_OFF_INT_SP 12'h004
`define CIFC_OFF_USER_SP 12'h008
`define CIFC_OFF_ASP 12'h00C
`define CIFC_OFF_SWI 12'h010
`define CIFC_OFF_STAT 12'h014
`define CIFC_OFF_BANK 12'h020
`define CIFC_OFF_BANK_LAST 12'h038

`define CIFC_FLAG_EN 0
`define CIFC_FLAG_STK 1
`define CIFC_FLAG_RSV 2
`define CIFC_FLAG_LVL_LO 4
`define CIFC_FLAG_LVL_HI 6
`define CIFC_FLAG_BANK 7

`define CIFC_RST_LEVEL 3'h0
`define CIFC_RST_SP 16'h0000
`define CIFC_RST_VEC 6'h00
`define CIFC_SWI_LOW_MAX 6'h1F
`define CIFC_BANK_REGS 7
`define CIFC_BANKS 2

`define CIFC_RESP_OKAY 2'h0
`define CIFC_RESP_SLVERR 2'h2

`endif

// ### hw/cifc_pkg.sv
// Types and decode helpers for the CPU interrupt flag control block.
// Assumes cifc_params.svh is on the include path.
`include "cifc_params.svh"

package cifc_pkg;

	typedef enum logic [2:0] {
		CIFC_R_FLAG,
		CIFC_R_INT_SP,
		CIFC_R_USER_SP,
		CIFC_R_ASP,
		CIFC_R_SWI,
		CIFC_R_STAT,
		CIFC_R_BANK,
		CIFC_R_NONE
	} cifc_reg_t;

	// Shared by the read and the write path
	function automatic cifc_reg_t cifc_decode(input logic [11:0] addr);
		cifc_reg_t sel;
		sel = CIFC_R_NONE;
		if (addr[1:0] == 2'h0) begin
			if (addr == `CIFC_OFF_FLAG) sel = CIFC_R_FLAG;
			else if (addr == `CIFC_OFF_INT_SP) sel = CIFC_R_INT_SP;
			else if (addr == `CIFC_OFF_USER_SP) sel = CIFC_R_USER_SP;
			else if (addr == `CIFC_OFF_ASP) sel = CIFC_R_ASP;
			else if (addr == `CIFC_OFF_SWI) sel = CIFC_R_SWI;
			else if (addr == `CIFC_OFF_STAT) sel = CIFC_R_STAT;
			else if (addr >= `CIFC_OFF_BANK && addr <= `CIFC_OFF_BANK_LAST) sel = CIFC_R_BANK;
		end
		return sel;
	endfunction : cifc_decode

	function automatic logic [15:0] cifc_merge16(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) res[7:0] = wd[7:0];
		if (strb[1]) res[15:8] = wd[15:8];
		return res;
	endfunction : cifc_merge16

endpackage : cifc_pkg

// ### hw/cifc_bank_if.sv
// Carrier between the flag control top and its banked register store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns

interface cifc_bank_if;
	logic wr_en;
	logic [2:0] wr_idx;
	logic [1:0] wr_strb;
	logic [15:0] wdata;
	logic [2:0] rd_idx;
	logic bank;
	logic [15:0] rdata;

	modport ctrl(output wr_en, output wr_idx, output wr_strb, output wdata, output rd_idx, output bank,
		input rdata);
	modport store(input wr_en, input wr_idx, input wr_strb, input wdata, input rd_idx, input bank,
		output rdata);
endinterface : cifc_bank_if

// ### hw/cifc_bank.sv
// Two banks of seven 16-bit registers: four general, two address, frame base.
// Assumes the top writes indexes 0 to 6 only and ignores what a read of index 7 returns.
`timescale 1ns/1ns
`include "cifc_params.svh"

module cifc_bank
	import cifc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	cifc_bank_if.store bus
);

	// Index 0..3 general_register_zero..three, 4/5 address_register_zero/one, 6 frame_base_register
	logic [15:0] mem [`CIFC_BANKS][`CIFC_BANK_REGS];

	genvar b;
	genvar r;
	generate
		for (b = 0; b < `CIFC_BANKS; b++) begin : g_bank
			for (r = 0; r < `CIFC_BANK_REGS; r++) begin : g_reg
				always_ff @(posedge core_clk_in or negedge rstn_in) begin
					if (!rstn_in) begin
						mem[b][r] <= 16'h0000;
					end else if (bus.wr_en && bus.bank == 1'(b) && bus.wr_idx == 3'(r)) begin
						mem[b][r] <= cifc_merge16(mem[b][r], bus.wdata, bus.wr_strb);
					end
				end
			end
		end
	endgenerate

	assign bus.rdata = mem[bus.bank][bus.rd_idx];

	chk_bank_write_lands: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		bus.wr_en && bus.wr_strb == 2'h3 |=> mem[$past(bus.bank)][$past(bus.wr_idx)] == $past(bus.wdata))
		else $error("banked register write lost");

endmodule : cifc_bank

// ### hw/cifc_top.sv
// CPU flag logic for interrupt acceptance, stack select, priority level and banks.
// Assumes an AXI4-Lite master and an interrupt controller on core_clk_in.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "cifc_params.svh"

// Operation
// - Maskable interrupts are blocked while the enable flag is 0 and allowed while it is 1.
// - Acknowledging any interrupt clears the enable flag to 0.
// - Stack select 0 picks the interrupt stack pointer, 1 the user stack pointer.
// - Stack select clears on a hardware acknowledge and on a software interrupt numbered 0 to 31.
// - The processor priority level is a 3-bit field holding levels 0 to 7.
// - A request is enabled only when its priority is strictly above the processor priority level.
// - The reserved flag bit should be written as 0 and has no defined read value.
// - There are 13 registers, with general, address and frame base registers in two banks.
module cifc_top
	import cifc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [11:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic irq_req_in,
	input wire logic [2:0] irq_pri_in,
	input wire logic [5:0] irq_vec_in,
	output logic irq_ack_out,
	output logic [5:0] ack_vec_out,
	output logic [15:0] active_sp_out,
	output logic [2:0] level_out,
	output logic mask_enable_out
);

	logic enable_flag;
	logic stack_sel;
	logic [2:0] processor_priority_level;
	logic bank_sel;
	logic [15:0] interrupt_stack_pointer;
	logic [15:0] user_stack_pointer;
	logic [5:0] last_vec;
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] wd;
	logic [3:0] ws;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic do_write;
	logic accept;
	logic swi_fire;
	logic flag_write;
	logic ar_take;
	cifc_reg_t wr_sel;
	cifc_reg_t rd_sel;
	logic [31:0] next_rdata;
	logic [15:0] active_sp;

	cifc_bank_if bank_bus();

	cifc_bank cifc_bank_inst (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.bus(bank_bus.store)
	);

	// Write channel: address and data are taken independently, acted on once both are held
	assign s_axi_awready_out = !aw_held;
	assign s_axi_wready_out = !w_held;
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_sel = cifc_decode(aw_addr);
	assign flag_write = do_write && wr_sel == CIFC_R_FLAG && ws[0];
	assign swi_fire = do_write && wr_sel == CIFC_R_SWI && ws[0];

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end else if (s_axi_awvalid_in && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_in;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			w_held <= 1'b0;
			wd <= 32'h00000000;
			ws <= 4'h0;
		end else if (s_axi_wvalid_in && !w_held) begin
			w_held <= 1'b1;
			wd <= s_axi_wdata_in;
			ws <= s_axi_wstrb_in;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bvalid <= 1'b0;
			bresp <= `CIFC_RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= (wr_sel == CIFC_R_NONE) ? `CIFC_RESP_SLVERR : `CIFC_RESP_OKAY;
		end else if (s_axi_bready_in) begin
			bvalid <= 1'b0;
		end
	end

	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out = bresp;

	assign accept = irq_req_in && enable_flag && (irq_pri_in > processor_priority_level);

	// Hardware events are applied last so they win over a software write in the same cycle
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			enable_flag <= 1'b0;
			stack_sel <= 1'b0;
			processor_priority_level <= `CIFC_RST_LEVEL;
			bank_sel <= 1'b0;
		end else begin
			if (flag_write) begin
				enable_flag <= wd[`CIFC_FLAG_EN];
				stack_sel <= wd[`CIFC_FLAG_STK];
				processor_priority_level <= wd[`CIFC_FLAG_LVL_HI:`CIFC_FLAG_LVL_LO];
				bank_sel <= wd[`CIFC_FLAG_BANK];
			end
			if (swi_fire) begin
				enable_flag <= 1'b0;
				if (wd[5:0] <= `CIFC_SWI_LOW_MAX) begin
					stack_sel <= 1'b0;
				end
			end
			if (accept) begin
				enable_flag <= 1'b0;
				stack_sel <= 1'b0;
				processor_priority_level <= irq_pri_in;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_ack_out <= 1'b0;
			last_vec <= `CIFC_RST_VEC;
		end else begin
			irq_ack_out <= accept;
			if (accept) begin
				last_vec <= irq_vec_in;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			interrupt_stack_pointer <= `CIFC_RST_SP;
			user_stack_pointer <= `CIFC_RST_SP;
		end else if (do_write) begin
			if (wr_sel == CIFC_R_INT_SP) begin
				interrupt_stack_pointer <= cifc_merge16(interrupt_stack_pointer, wd[15:0], ws[1:0]);
			end
			if (wr_sel == CIFC_R_USER_SP) begin
				user_stack_pointer <= cifc_merge16(user_stack_pointer, wd[15:0], ws[1:0]);
			end
		end
	end

	assign active_sp = stack_sel ? user_stack_pointer : interrupt_stack_pointer;

	assign ack_vec_out = last_vec;
	assign active_sp_out = active_sp;
	assign level_out = processor_priority_level;
	assign mask_enable_out = enable_flag;

	// bank access follows the bank flag
	assign bank_bus.wr_en = do_write && wr_sel == CIFC_R_BANK;
	assign bank_bus.wr_idx = aw_addr[4:2];
	assign bank_bus.wr_strb = ws[1:0];
	assign bank_bus.wdata = wd[15:0];
	assign bank_bus.rd_idx = s_axi_araddr_in[4:2];
	assign bank_bus.bank = bank_sel;

	// Read channel: one read in flight, answered the cycle after the address is taken
	assign s_axi_arready_out = !rvalid;
	assign ar_take = s_axi_arvalid_in && !rvalid;
	assign rd_sel = cifc_decode(s_axi_araddr_in);

	always_comb begin
		next_rdata = 32'h00000000;
		case (rd_sel)
			CIFC_R_FLAG: begin
				// Reserved bit reads as zero
				next_rdata[`CIFC_FLAG_EN] = enable_flag;
				next_rdata[`CIFC_FLAG_STK] = stack_sel;
				next_rdata[`CIFC_FLAG_LVL_HI:`CIFC_FLAG_LVL_LO] = processor_priority_level;
				next_rdata[`CIFC_FLAG_BANK] = bank_sel;
			end
			CIFC_R_INT_SP: next_rdata[15:0] = interrupt_stack_pointer;
			CIFC_R_USER_SP: next_rdata[15:0] = user_stack_pointer;
			CIFC_R_ASP: next_rdata[15:0] = active_sp;
			CIFC_R_STAT: begin
				next_rdata[0] = irq_req_in;
				next_rdata[13:8] = last_vec;
			end
			CIFC_R_BANK: next_rdata[15:0] = bank_bus.rdata;
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `CIFC_RESP_OKAY;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= (rd_sel == CIFC_R_NONE) ? `CIFC_RESP_SLVERR : `CIFC_RESP_OKAY;
		end else if (s_axi_rready_in) begin
			rvalid <= 1'b0;
		end
	end

	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rdata_out = rdata;
	assign s_axi_rresp_out = rresp;

	chk_ack_needs_enable: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		irq_ack_out |-> $past(enable_flag))
		else $error("acknowledge issued with enable flag low");

	chk_ack_clears_enable: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		irq_ack_out |-> !enable_flag && !mask_enable_out)
		else $error("enable flag not cleared on acknowledge");

	chk_active_sp_read: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		ar_take && rd_sel == CIFC_R_ASP |=> s_axi_rvalid_out &&
		s_axi_rdata_out[15:0] == ($past(stack_sel) ? $past(user_stack_pointer) : $past(interrupt_stack_pointer)))
		else $error("active stack pointer read wrong");

	chk_ack_clears_stack: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		irq_ack_out |-> !stack_sel)
		else $error("stack select not cleared on acknowledge");

	chk_swi_low_stack: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		swi_fire && wd[5:0] <= `CIFC_SWI_LOW_MAX |=> !stack_sel && !enable_flag)
		else $error("low software interrupt left flags set");

	chk_level_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		flag_write && !accept |=> level_out == $past(wd[6:4]))
		else $error("priority level field not written");

	chk_ack_priority: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		irq_ack_out |-> $past(irq_pri_in) > $past(processor_priority_level) && level_out == $past(irq_pri_in))
		else $error("acknowledge without higher priority");

	chk_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		ar_take && rd_sel == CIFC_R_FLAG |=> s_axi_rdata_out[3:2] == 2'h0)
		else $error("reserved flag bit read nonzero");

	chk_pending_held: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		irq_req_in && !enable_flag |=> !irq_ack_out)
		else $error("masked request acknowledged");

	chk_pri_not_above: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		irq_req_in && irq_pri_in <= processor_priority_level |=> !irq_ack_out)
		else $error("request at or below level acknowledged");

	chk_ack_single_pulse: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		irq_ack_out |=> !irq_ack_out)
		else $error("acknowledge lasted more than one cycle");

	chk_swi_high_stack: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
		swi_fire && wd[5:0] > `CIFC_SWI_LOW_MAX && !accept |=> stack_sel == $past(stack_sel))
		else $error("high software interrupt changed stack select");

endmodule : cifc_top

// ### test/cifc_irq_ctrl.sv
// Stand-in for the interrupt controller: holds one prioritised request until it is acknowledged.
// Assumes the bench raises or withdraws requests with one-cycle pulses on core_clk_in.
`timescale 1ns/1ns

module cifc_irq_ctrl (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic raise_in,
	input wire logic drop_in,
	input wire logic [2:0] pri_in,
	input wire logic [5:0] vec_in,
	input wire logic ack_in,
	output logic req_out,
	output logic [2:0] pri_out,
	output logic [5:0] vec_out
);
	logic [2:0] pri;
	logic [5:0] vec;

	// Idle lines show the inverse of the last value so a stale copy is never trusted
	assign pri_out = req_out ? pri : ~pri;
	assign vec_out = req_out ? vec : ~vec;

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			req_out <= 1'b0;
			pri <= 3'h0;
			vec <= 6'h00;
		end else if (ack_in || drop_in) begin
			req_out <= 1'b0;
		end else if (raise_in) begin
			req_out <= 1'b1;
			pri <= pri_in;
			vec <= vec_in;
		end
	end
endmodule : cifc_irq_ctrl

// ### test/cpu_interrupt_flag_control_tb.sv
// Self-checking bench for the flag control block, driven over its register bus.
// Assumes cifc_params.svh on the include path and the controller stand-in beside it.
`timescale 1ns/1ns
`include "cifc_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin fails++; $display("[ERR] %s exp=%h got=%h", nm, e, g); end end

module cpu_interrupt_flag_control_tb;
	localparam logic [1:0] ok = `CIFC_RESP_OKAY;
	localparam logic [1:0] se = `CIFC_RESP_SLVERR;
	localparam logic [11:0] a_flag = `CIFC_OFF_FLAG;
	localparam logic [31:0] all1 = 32'hFFFFFFFF;
	localparam logic [31:0] fmask = 32'hFFFFFFFB;
	logic clk, awready, wready, bvalid, arready, rvalid, req, ack, men;
	logic rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic raise = 1'b0, drop = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic [2:0] pri_set = 3'h0, pri, level;
	logic [5:0] vec_set = 6'h00, vec, ack_vec;
	logic [15:0] sp;
	int fails = 0;
	int num_checks = 0;

	cifc_top cifc_top_inst (.core_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .irq_req_in(req), .irq_pri_in(pri), .irq_vec_in(vec),
		.irq_ack_out(ack), .ack_vec_out(ack_vec), .active_sp_out(sp), .level_out(level),
		.mask_enable_out(men));

	cifc_irq_ctrl cifc_irq_ctrl_inst (.core_clk_in(clk), .rstn_in(rstn), .raise_in(raise),
		.drop_in(drop), .pri_in(pri_set), .vec_in(vec_set), .ack_in(ack), .req_out(req),
		.pri_out(pri), .vec_out(vec));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		`CHK("bvalid", 1'b1, bvalid)
		`CHK("bresp", er, bresp)
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		`CHK("rvalid", 1'b1, rvalid)
		`CHK("rresp", er, rresp)
		`CHK("rdata", e & m, rdata & m)
	endtask : rd

	// reserved bit always written as 0
	function automatic logic [31:0] fl(input logic en, input logic stk, input logic [2:0] lv, input logic bk);
		return {24'h000000, bk, lv, 1'b0, 1'b0, stk, en};
	endfunction : fl

	task automatic setf(input logic en, input logic stk, input logic [2:0] lv, input logic bk);
		wr(a_flag, fl(en, stk, lv, bk), 4'h1, ok);
	endtask : setf

	task automatic ctl(input logic up, input logic [2:0] p, input logic [5:0] v);
		@(posedge clk);
		raise <= up;
		drop <= !up;
		pri_set <= p;
		vec_set <= v;
		@(posedge clk);
		raise <= 1'b0;
		drop <= 1'b0;
	endtask : ctl

	// One-cycle pulses, so count them at every falling edge
	task automatic ack_cnt(input int exp_n);
		int c;
		c = 0;
		repeat (12) begin
			@(negedge clk);
			// An unknown acknowledge counts, so it cannot slip past an expected zero
			if (ack !== 1'b0) c++;
		end
		`CHK("acks", exp_n, c)
	endtask : ack_cnt

	task wrap_up;
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// The run needs well under a thousand cycles; this bound of 50000 cycles leaves wide margin
	initial begin
		#500000;
		fails++;
		wrap_up();
	end

	initial begin : main
		int k;
		logic [5:0] nums [4];
		nums = '{6'h00, 6'h1F, 6'h20, 6'h3F};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(a_flag, 32'h0, fmask, ok);
		`CHK("enable", 1'b0, men)
		$display("test reset done");
		wr(`CIFC_OFF_INT_SP, 32'h1234, 4'h3, ok);
		wr(`CIFC_OFF_USER_SP, 32'hABCD, 4'h3, ok);
		wr(`CIFC_OFF_INT_SP, 32'hFF56, 4'h1, ok);
		setf(1'b0, 1'b1, 3'h0, 1'b0);
		`CHK("sp", 16'hABCD, sp)
		rd(`CIFC_OFF_ASP, 32'hABCD, all1, ok);
		setf(1'b0, 1'b0, 3'h0, 1'b0);
		rd(`CIFC_OFF_ASP, 32'h1256, all1, ok);
		$display("test stack done");
		setf(1'b0, 1'b1, 3'h0, 1'b0);
		ctl(1'b1, 3'h5, 6'h2A);
		ack_cnt(0);
		rd(`CIFC_OFF_STAT, 32'h1, 32'h1, ok);
		setf(1'b1, 1'b1, 3'h5, 1'b0);
		ack_cnt(0);
		ctl(1'b1, 3'h6, 6'h15);
		ack_cnt(1);
		`CHK("enable", 1'b0, men)
		`CHK("sp", 16'h1256, sp)
		`CHK("vec", 6'h15, ack_vec)
		rd(a_flag, fl(1'b0, 1'b0, 3'h6, 1'b0), fmask, ok);
		rd(`CIFC_OFF_STAT, 32'h1500, 32'h3F01, ok);
		$display("test accept done");
		for (k = 0; k < 8; k++) begin
			setf(1'b1, 1'b1, k[2:0], 1'b0);
			ctl(1'b1, k[2:0], k[5:0]);
			ack_cnt(0);
			if (k < 7) begin
				ctl(1'b1, k[2:0] + 3'h1, 6'h30);
				ack_cnt(1);
				`CHK("level", k[2:0] + 3'h1, level)
				`CHK("enable", 1'b0, men)
				`CHK("sp", 16'h1256, sp)
			end else begin
				rd(a_flag, fl(1'b1, 1'b1, 3'h7, 1'b0), fmask, ok);
				ctl(1'b0, 3'h0, 6'h00);
			end
		end
		$display("test levels done");
		for (k = 0; k < 4; k++) begin
			setf(1'b1, 1'b1, 3'h0, 1'b0);
			wr(`CIFC_OFF_SWI, {26'h0, nums[k]}, 4'h1, ok);
			`CHK("enable", 1'b0, men)
			`CHK("sp", (nums[k] <= 6'h1F) ? 16'h1256 : 16'hABCD, sp)
		end
		$display("test soft done");
		for (k = 0; k < 28; k++) begin
			if (k % 7 == 0) setf(1'b0, 1'b0, 3'h0, (k % 14) >= 7);
			if (k < 14) wr(12'(`CIFC_OFF_BANK + 4 * (k % 7)), 32'hB000 + k, 4'h3, ok);
			else rd(12'(`CIFC_OFF_BANK + 4 * (k % 7)), 32'hB000 + k - 14, all1, ok);
		end
		$display("test banks done");
		rd(12'h03C, 32'h0, all1, se);
		rd(12'h002, 32'h0, all1, se);
		wr(12'h041, 32'h1, 4'h1, se);
		wr(`CIFC_OFF_ASP, 32'h5555, 4'h3, ok);
		rd(`CIFC_OFF_ASP, 32'h1256, all1, ok);
		$display("test decode done");
		wrap_up();
	end
endmodule : cpu_interrupt_flag_control_tb
